// ===== camera_event_notifier.sv
// Camera event notifier: per-milestone records, APB registers, ordered notification queue.
// Assumes milestone pulses and frame identifier come from logic on clk; host drains noteRecord.
//
// Overview of operation
// - Selector codes 0-9, 28, 29, 99 choose milestone
// - Red/blue exposure milestones only on trilinear variant
// - Per-milestone notify enable, 0 off, resets off
// - Enabled occurrence yields one notification, none if its slot's previous one is still pending
// - Each notification carries fixed milestone code
// - Occurrence latches 64-bit timestamp into record
// - Timestamp fields read zero until first occurrence
// - Occurrence captures current frame identifier
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module camera_event_notifier #(
    parameter logic TRILINEAR   = 1'b1,
    parameter int   QUEUE_DEPTH = 4
) (
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic        [cen_pkg::ADDR_W-1:0] paddr,
    input  wire logic        [31:0]                pwdata,
    output logic             [31:0]                prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic      [cen_pkg::NUM_SLOTS-1:0] milestoneHit,
    input  wire logic        [cen_pkg::FRAME_W-1:0] frameIdentifier,
    output logic                                   noteValid,
    input  wire logic                              noteReady,
    output cen_pkg::cen_record_t                   noteRecord,
    output logic                                   irq
);
    localparam int N = cen_pkg::NUM_SLOTS;

    // Register state
    logic [cen_pkg::SEL_W-1:0]                 milestoneSelect;
    logic [cen_pkg::SEL_W-1:0]                 next_milestoneSelect;
    logic [N-1:0]                              notifyEnable;
    logic [N-1:0]                              next_notifyEnable;
    logic [cen_pkg::IRQ_W-1:0]                 irqStatus;
    logic [cen_pkg::IRQ_W-1:0]                 next_irqStatus;
    logic [cen_pkg::IRQ_W-1:0]                 irqMask;
    logic [cen_pkg::IRQ_W-1:0]                 next_irqMask;
    logic [31:0]                               next_prdata;

    // Record state
    logic [cen_pkg::STAMP_W-1:0]               stampCounter;
    logic [cen_pkg::STAMP_W-1:0]               next_stampCounter;
    logic [N-1:0][cen_pkg::STAMP_W-1:0]        stampRec;
    logic [N-1:0][cen_pkg::STAMP_W-1:0]        next_stampRec;
    logic [N-1:0][cen_pkg::FRAME_W-1:0]        frameRec;
    logic [N-1:0][cen_pkg::FRAME_W-1:0]        next_frameRec;

    // Ordering state: olderThan[i][j] set means pending j arrived before pending i
    logic [N-1:0]                              pending;
    logic [N-1:0]                              next_pending;
    cen_pkg::cen_record_t [N-1:0]              pendRec;
    cen_pkg::cen_record_t [N-1:0]              next_pendRec;
    logic [N-1:0][N-1:0]                       olderThan;
    logic [N-1:0][N-1:0]                       next_olderThan;

    logic [N-1:0]                              allowed;
    logic [N-1:0]                              hit;
    logic [N-1:0]                              notify;
    logic [N-1:0]                              accept;
    logic [N-1:0]                              grant;
    logic                                      dropped;
    logic                                      pushValid;
    logic                                      pushReady;
    cen_pkg::cen_record_t                      pushRec;
    cen_pkg::cen_slot_t                        selSlot;
    logic                                      setupPhase;
    logic                                      accessPhase;
    logic                                      mapped;
    logic                                      writeTake;

    assign allowed = TRILINEAR ? {N{1'b1}} : ~cen_pkg::COLOUR_ONLY_MASK;
    assign hit     = milestoneHit & allowed;
    assign notify  = hit & notifyEnable;
    assign selSlot = cen_pkg::cen_slot_of(milestoneSelect);

    // Oldest pending slot wins; ties in one cycle go to the lower slot
    always_comb begin
        grant   = '0;
        pushRec = '0;
        for (int i = 0; i < N; i++) begin
            grant[i] = pending[i] && ((olderThan[i] & pending) == '0) && pushReady;
        end
        for (int i = 0; i < N; i++) begin
            if (grant[i]) begin
                pushRec = pushRec | pendRec[i];
            end
        end
        pushValid = (pending != '0);
    end

    always_comb begin
        next_stampCounter = stampCounter + 1'b1;
        next_stampRec     = stampRec;
        next_frameRec     = frameRec;
        next_pending      = pending;
        next_pendRec      = pendRec;
        next_olderThan    = olderThan;
        accept            = '0;
        dropped           = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                next_stampRec[i] = stampCounter;
                next_frameRec[i] = frameIdentifier;
            end
            if (notify[i] && pending[i] && !grant[i]) begin
                // Older record still waiting: keep it, report the loss
                dropped = 1'b1;
            end else if (notify[i]) begin
                accept[i]                       = 1'b1;
                next_pending[i]                 = 1'b1;
                next_pendRec[i].milestoneCode   = cen_pkg::MILESTONE_CODES[i];
                next_pendRec[i].stamp           = stampCounter;
                next_pendRec[i].frameIdentifier = frameIdentifier;
            end else if (grant[i]) begin
                next_pending[i] = 1'b0;
            end
        end
        for (int i = 0; i < N; i++) begin
            for (int j = 0; j < N; j++) begin
                if (accept[i]) begin
                    next_olderThan[i][j] = (pending[j] && !grant[j])
                                           || (accept[j] && (j < i));
                end else if (accept[j]) begin
                    next_olderThan[i][j] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stampCounter <= '0;
            stampRec     <= '0;
            frameRec     <= '0;
            pending      <= '0;
            pendRec      <= '0;
            olderThan    <= '0;
        end else begin
            stampCounter <= next_stampCounter;
            stampRec     <= next_stampRec;
            frameRec     <= next_frameRec;
            pending      <= next_pending;
            pendRec      <= next_pendRec;
            olderThan    <= next_olderThan;
        end
    end

    cen_note_fifo #(
        .WIDTH (cen_pkg::RECORD_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk      (clk),
        .rst_b    (rst_b),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushRec),
        .outValid (noteValid),
        .outReady (noteReady),
        .outData  (noteRecord)
    );

    // APB slave: zero wait states, read data prepared during setup
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign pready      = 1'b1;
    assign pslverr     = accessPhase && !mapped;
    assign writeTake   = accessPhase && pwrite && mapped;
    assign irq         = (irqStatus & irqMask) != '0;

    always_comb begin
        unique case (paddr)
            cen_pkg::REG_SELECT, cen_pkg::REG_ENABLE, cen_pkg::REG_CODE,
            cen_pkg::REG_STAMPLO, cen_pkg::REG_STAMPHI, cen_pkg::REG_FRAME,
            cen_pkg::REG_IRQSTAT, cen_pkg::REG_IRQMASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_milestoneSelect = milestoneSelect;
        next_notifyEnable    = notifyEnable;
        next_irqMask         = irqMask;
        next_irqStatus       = irqStatus;
        next_prdata          = prdata;
        if (writeTake) begin
            unique case (paddr)
                cen_pkg::REG_SELECT: begin
                    next_milestoneSelect = pwdata[cen_pkg::SEL_W-1:0];
                end
                cen_pkg::REG_ENABLE: begin
                    if (selSlot.valid) begin
                        next_notifyEnable[selSlot.slot] = pwdata[0] && allowed[selSlot.slot];
                    end
                end
                cen_pkg::REG_IRQSTAT: begin
                    next_irqStatus = irqStatus & ~pwdata[cen_pkg::IRQ_W-1:0];
                end
                cen_pkg::REG_IRQMASK: begin
                    next_irqMask = pwdata[cen_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // A new event outranks a write-one-to-clear in the same cycle
        if (grant != '0) begin
            next_irqStatus[cen_pkg::IRQ_QUEUED] = 1'b1;
        end
        if (dropped) begin
            next_irqStatus[cen_pkg::IRQ_DROPPED] = 1'b1;
        end
        if (setupPhase) begin
            next_prdata = '0;
            unique case (paddr)
                cen_pkg::REG_SELECT: begin
                    next_prdata[cen_pkg::SEL_W-1:0] = milestoneSelect;
                end
                cen_pkg::REG_ENABLE: begin
                    next_prdata[0] = selSlot.valid && notifyEnable[selSlot.slot];
                end
                cen_pkg::REG_CODE: begin
                    if (selSlot.valid && allowed[selSlot.slot]) begin
                        next_prdata[cen_pkg::CODE_W-1:0] = cen_pkg::MILESTONE_CODES[selSlot.slot];
                    end
                end
                cen_pkg::REG_STAMPLO: begin
                    if (selSlot.valid) begin
                        next_prdata = stampRec[selSlot.slot][31:0];
                    end
                end
                cen_pkg::REG_STAMPHI: begin
                    if (selSlot.valid) begin
                        next_prdata = stampRec[selSlot.slot][63:32];
                    end
                end
                cen_pkg::REG_FRAME: begin
                    if (selSlot.valid) begin
                        next_prdata = frameRec[selSlot.slot];
                    end
                end
                cen_pkg::REG_IRQSTAT: begin
                    next_prdata[cen_pkg::IRQ_W-1:0] = irqStatus;
                end
                cen_pkg::REG_IRQMASK: begin
                    next_prdata[cen_pkg::IRQ_W-1:0] = irqMask;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            milestoneSelect <= cen_pkg::SELECT_RESET;
            notifyEnable    <= cen_pkg::ENABLE_RESET;
            irqStatus       <= cen_pkg::IRQ_RESET;
            irqMask         <= cen_pkg::IRQ_RESET;
            prdata          <= '0;
        end else begin
            milestoneSelect <= next_milestoneSelect;
            notifyEnable    <= next_notifyEnable;
            irqStatus       <= next_irqStatus;
            irqMask         <= next_irqMask;
            prdata          <= next_prdata;
        end
    end

endmodule

// ===== cen_pkg.sv
// Constants, register map and record layout of the camera event notifier.
// Assumes a 32-bit APB register bus and one 200 MHz clock.
package cen_pkg;

    localparam int NUM_SLOTS = 13;
    localparam int SLOT_W    = 4;
    localparam int SEL_W     = 7;
    localparam int ADDR_W    = 8;
    localparam int FRAME_W   = 32;
    localparam int STAMP_W   = 64;
    localparam int CODE_W    = 16;
    localparam int IRQ_W     = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_SELECT  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ENABLE  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CODE    = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STAMPLO = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STAMPHI = 8'h10;
    localparam logic [ADDR_W-1:0] REG_FRAME   = 8'h14;
    localparam logic [ADDR_W-1:0] REG_IRQSTAT = 8'h18;
    localparam logic [ADDR_W-1:0] REG_IRQMASK = 8'h1C;

    // Interrupt status bit positions
    localparam int IRQ_QUEUED  = 0;
    localparam int IRQ_DROPPED = 1;

    // Reset values
    localparam logic [SEL_W-1:0]     SELECT_RESET = 7'h00;
    localparam logic [NUM_SLOTS-1:0] ENABLE_RESET = 13'h0000;
    localparam logic [IRQ_W-1:0]     IRQ_RESET    = 2'h0;

    // Selector codes
    localparam logic [SEL_W-1:0] SEL_LINE_BEGIN  = 7'h1C;
    localparam logic [SEL_W-1:0] SEL_LINE_FINISH = 7'h1D;
    localparam logic [SEL_W-1:0] SEL_ERROR       = 7'h63;
    localparam logic [SEL_W-1:0] SEL_LAST_PLAIN  = 7'h09;

    // Slots 10, 11, 12 hold line-valid begin, finish and error
    localparam logic [SLOT_W-1:0] SLOT_LINE_BEGIN  = 4'hA;
    localparam logic [SLOT_W-1:0] SLOT_LINE_FINISH = 4'hB;
    localparam logic [SLOT_W-1:0] SLOT_ERROR       = 4'hC;

    // Red and blue exposure slots exist only on the trilinear variant
    localparam logic [NUM_SLOTS-1:0] COLOUR_ONLY_MASK = 13'h0330;

    localparam logic [CODE_W-1:0] ERROR_CODE = 16'h9FFF;

    // Element [0] is the last entry in the list
    localparam logic [NUM_SLOTS-1:0][CODE_W-1:0] MILESTONE_CODES = '{
        ERROR_CODE, 16'h9331, 16'h9330, 16'h9307, 16'h9306, 16'h9305, 16'h9304,
        16'h9303, 16'h9302, 16'h9301, 16'h9300, 16'h9012, 16'h9011
    };

    typedef struct packed {
        logic [CODE_W-1:0]  milestoneCode;
        logic [STAMP_W-1:0] stamp;
        logic [FRAME_W-1:0] frameIdentifier;
    } cen_record_t;

    localparam int RECORD_W = CODE_W + STAMP_W + FRAME_W;

    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
    } cen_slot_t;

    function automatic cen_slot_t cen_slot_of(input logic [SEL_W-1:0] code);
        cen_slot_t s;
        s.valid = 1'b1;
        s.slot  = code[SLOT_W-1:0];
        if (code == SEL_LINE_BEGIN) begin
            s.slot = SLOT_LINE_BEGIN;
        end else if (code == SEL_LINE_FINISH) begin
            s.slot = SLOT_LINE_FINISH;
        end else if (code == SEL_ERROR) begin
            s.slot = SLOT_ERROR;
        end else if (code > SEL_LAST_PLAIN) begin
            s.valid = 1'b0;
            s.slot  = 4'h0;
        end
        return s;
    endfunction

endpackage

// ===== cen_note_fifo.sv
// Small flip-flop queue for notification records.
// Assumes the filling and draining sides share clk.
`timescale 1ns/1ps
module cen_note_fifo #(
    parameter int WIDTH = 112,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0][WIDTH-1:0] next_mem;
    logic [PTR_W-1:0]            wrPtr;
    logic [PTR_W-1:0]            next_wrPtr;
    logic [PTR_W-1:0]            rdPtr;
    logic [PTR_W-1:0]            next_rdPtr;
    logic [CNT_W-1:0]            count;
    logic [CNT_W-1:0]            next_count;
    logic                        doWrite;
    logic                        doRead;

    assign inReady  = (count != CNT_FULL);
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    always_comb begin
        doWrite    = inValid && inReady;
        doRead     = outValid && outReady;
        next_mem   = mem;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (doWrite) begin
            next_mem[wrPtr] = inData;
            next_wrPtr      = (wrPtr == PTR_LAST) ? '0 : wrPtr + 1'b1;
        end
        if (doRead) begin
            next_rdPtr = (rdPtr == PTR_LAST) ? '0 : rdPtr + 1'b1;
        end
        if (doWrite && !doRead) begin
            next_count = count + 1'b1;
        end else if (doRead && !doWrite) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem   <= '0;
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            mem   <= next_mem;
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

endmodule

// ===== cen_properties.sv
// Port-level checker for the camera event notifier, bound into every instance.
// Assumes one clock and the active-low reset of the design itself.
`timescale 1ns/1ps
module cen_properties #(
    parameter logic TRILINEAR = 1'b1
) (
    input wire logic                          clk,
    input wire logic                          rst_b,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [cen_pkg::ADDR_W-1:0]    paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic                          pready,
    input wire logic [cen_pkg::NUM_SLOTS-1:0] milestoneHit,
    input wire logic [cen_pkg::FRAME_W-1:0]   frameIdentifier,
    input wire logic                          noteValid,
    input wire logic                          noteReady,
    input wire cen_pkg::cen_record_t          noteRecord
);
    logic [63:0] cnt;
    logic [63:0] next_cnt;
    logic        anyEn;
    logic        next_anyEn;

    // Mirror of the free-running stamp counter
    always_comb begin
        next_cnt   = cnt + 64'h1;
        next_anyEn = anyEn | (psel && penable && pwrite && pready
                              && paddr == cen_pkg::REG_ENABLE && pwdata[0]);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt   <= 64'h0;
            anyEn <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            anyEn <= next_anyEn;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_pop;
        noteValid && noteReady;
    endsequence
    sequence s_stall;
        noteValid && !noteReady;
    endsequence

    property p_hold;
        s_stall |=> noteValid && $stable(noteRecord);
    endproperty
    a_hold: assert property (p_hold) else $error("record changed while stalled");

    property p_order;
        s_pop ##1 noteValid |-> noteRecord.stamp >= $past(noteRecord.stamp);
    endproperty
    a_order: assert property (p_order) else $error("records out of order");

    property p_cause;
        $rose(noteValid) |-> $past(milestoneHit, 2) != 13'h0000;
    endproperty
    a_cause: assert property (p_cause) else $error("note without a hit");

    property p_code;
        noteValid |-> noteRecord.milestoneCode inside {16'h9011, 16'h9012, 16'h9300,
            16'h9301, 16'h9302, 16'h9303, 16'h9304, 16'h9305, 16'h9306, 16'h9307,
            16'h9330, 16'h9331, 16'h9FFF};
    endproperty
    a_code: assert property (p_code) else $error("unknown milestone code");

    property p_mono;
        noteValid && !TRILINEAR |-> !(noteRecord.milestoneCode inside
            {16'h9302, 16'h9303, 16'h9306, 16'h9307});
    endproperty
    a_mono: assert property (p_mono) else $error("colour note on mono");

    property p_stamp;
        $rose(noteValid) |-> noteRecord.stamp == cnt - 64'h2;
    endproperty
    a_stamp: assert property (p_stamp) else $error("wrong stamp in note");

    property p_frame;
        $rose(noteValid) |-> noteRecord.frameIdentifier == $past(frameIdentifier, 2);
    endproperty
    a_frame: assert property (p_frame) else $error("wrong frame in note");

    property p_off;
        !anyEn |-> !noteValid;
    endproperty
    a_off: assert property (p_off) else $error("note while all disabled");
endmodule

bind camera_event_notifier cen_properties #(.TRILINEAR(TRILINEAR)) i_cen_properties (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .milestoneHit(milestoneHit),
    .frameIdentifier(frameIdentifier), .noteValid(noteValid), .noteReady(noteReady),
    .noteRecord(noteRecord)
);

// ===== cen_host_model.sv
// Host that drains notification records and keeps them for the bench.
// Assumes the bench steers stall and slow between transfers.
`timescale 1ns/1ps
module cen_host_model (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 stall,
    input  wire logic                 slow,
    input  wire logic                 noteValid,
    input  wire cen_pkg::cen_record_t noteRecord,
    output logic                      noteReady
);
    cen_pkg::cen_record_t got[$];

    // Slow mode takes every other cycle, to leave records waiting
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            noteReady <= 1'b0;
        end else begin
            if (noteValid && noteReady) begin
                got.push_back(noteRecord);
            end
            noteReady <= !stall && !(slow && noteReady);
        end
    end
endmodule

// ===== tb_camera_event_notifier.sv
// Register and notification tests of the colour event notifier; the mono variant is checked on register reads only.
// Assumes a zero-wait APB slave and records two cycles after a hit.
`timescale 1ns/1ps
module tb_camera_event_notifier;
    logic                 clk = 1'b0;
    logic                 rst_b = 1'b0;
    logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0, prdata, monoPrdata, rd;
    logic                 pready, pslverr, noteValid, noteReady, irq, er;
    logic                 stall = 1'b1, slow = 1'b0;
    logic [12:0]          milestoneHit = 13'h0000, en = 13'h0000;
    logic [31:0]          frameIdentifier = 32'h0;
    logic [63:0]          tbStamp, lastStamp;
    cen_pkg::cen_record_t noteRecord, expq[$];
    logic [15:0]          codeTab [13] = '{16'h9011, 16'h9012, 16'h9300, 16'h9301,
        16'h9302, 16'h9303, 16'h9304, 16'h9305, 16'h9306, 16'h9307, 16'h9330,
        16'h9331, 16'h9FFF};
    logic [6:0]           selTab [13] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
        7'h06, 7'h07, 7'h08, 7'h09, 7'h1C, 7'h1D, 7'h63};
    int                   errors = 0, n_tests = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) tbStamp <= 64'h0;
        else tbStamp <= tbStamp + 64'h1;
    end

    camera_event_notifier i_camera_event_notifier (.clk(clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .milestoneHit(milestoneHit),
        .frameIdentifier(frameIdentifier), .noteValid(noteValid), .noteReady(noteReady),
        .noteRecord(noteRecord), .irq(irq));
    // Mono twin shares the bus; only its read data is watched
    camera_event_notifier #(.TRILINEAR(1'b0)) i_camera_event_notifier_mono (.clk(clk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(monoPrdata), .pready(), .pslverr(),
        .milestoneHit(milestoneHit), .frameIdentifier(frameIdentifier), .noteValid(),
        .noteReady(1'b1), .noteRecord(), .irq());
    cen_host_model i_cen_host_model (.clk(clk), .rst_b(rst_b), .stall(stall), .slow(slow),
        .noteValid(noteValid), .noteRecord(noteRecord), .noteReady(noteReady));

    task automatic end_sim();
        if (errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [127:0] g, input logic [127:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask

    // Waits for the slave as long as it takes; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask

    // Keep is low for an occurrence that must be dropped
    task automatic pulse(input logic [12:0] m, input logic [31:0] f, input logic keep);
        @(posedge clk);
        milestoneHit <= m;
        frameIdentifier <= f;
        #1;
        lastStamp = tbStamp;
        for (int i = 0; i < 13; i++) begin
            if (m[i] && en[i] && keep) expq.push_back({codeTab[i], tbStamp, f});
        end
        @(posedge clk);
        milestoneHit <= 13'h0000;
    endtask

    task automatic drain();
        for (int n = 0; n < 200 && i_cen_host_model.got.size() < expq.size(); n++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        cmp(i_cen_host_model.got.size(), expq.size());
        foreach (expq[k]) if (k < i_cen_host_model.got.size())
            cmp(i_cen_host_model.got[k], expq[k]);
        expq.delete();
        i_cen_host_model.got.delete();
    endtask

    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(cen_pkg::REG_SELECT, 32'h0);
        rdchk(cen_pkg::REG_ENABLE, 32'h0);
        rdchk(cen_pkg::REG_CODE, 32'h9011);
        rdchk(cen_pkg::REG_STAMPLO, 32'h0);
        rdchk(cen_pkg::REG_STAMPHI, 32'h0);
        rdchk(cen_pkg::REG_IRQSTAT, 32'h0);
        rdchk(cen_pkg::REG_IRQMASK, 32'h0);
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, cen_pkg::REG_SELECT, {25'h0, selTab[i]});
            rdchk(cen_pkg::REG_SELECT, {25'h0, selTab[i]});
            rdchk(cen_pkg::REG_CODE, {16'h0, codeTab[i]});
            cmp(monoPrdata, (i inside {4, 5, 8, 9}) ? 32'h0 : {16'h0, codeTab[i]});
            rdchk(cen_pkg::REG_ENABLE, 32'h0);
            apb(1'b1, cen_pkg::REG_ENABLE, 32'h1);
            rdchk(cen_pkg::REG_ENABLE, 32'h1);
        end
        en = 13'h1FFF;
        apb(1'b1, cen_pkg::REG_SELECT, 32'h0A);
        rdchk(cen_pkg::REG_CODE, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        cmp({er, rd}, 33'h100000000);
        apb(1'b1, cen_pkg::REG_IRQMASK, 32'h1);
        // Same-cycle pair then a single, host taking every other cycle
        stall <= 1'b0;
        slow <= 1'b1;
        pulse(13'h0408, 32'h11, 1'b1);
        pulse(13'h0004, 32'h22, 1'b1);
        drain();
        cmp(irq, 1'b1);
        apb(1'b1, cen_pkg::REG_IRQSTAT, 32'h3);
        rdchk(cen_pkg::REG_IRQSTAT, 32'h0);
        cmp(irq, 1'b0);
        // Disabled milestone still updates its record
        apb(1'b1, cen_pkg::REG_SELECT, 32'h1);
        apb(1'b1, cen_pkg::REG_ENABLE, 32'h0);
        en[1] = 1'b0;
        pulse(13'h0002, 32'h33, 1'b1);
        rdchk(cen_pkg::REG_STAMPLO, lastStamp[31:0]);
        rdchk(cen_pkg::REG_STAMPHI, lastStamp[63:32]);
        rdchk(cen_pkg::REG_FRAME, 32'h33);
        drain();
        apb(1'b1, cen_pkg::REG_SELECT, 32'h4);
        pulse(13'h0010, 32'h44, 1'b1);
        rdchk(cen_pkg::REG_STAMPLO, lastStamp[31:0]);
        cmp(monoPrdata, 32'h0);
        drain();
        // Stalled host: queue fills, then a repeat of a pending slot is dropped
        stall <= 1'b1;
        slow <= 1'b0;
        for (int k = 0; k < 6; k++) pulse(13'h0001, 32'(k), k < 5);
        rdchk(cen_pkg::REG_IRQSTAT, 32'h3);
        stall <= 1'b0;
        drain();
        end_sim();
    end
endmodule
